//--- src/nand_chain_pkg.sv
// Purpose: shared constants for the pin-connectivity chain test
// Assumes: one clock, chain of 49 inputs, output at position 50
// Notes: strap code selecting chain mode is a plain parameter
package nand_chain_pkg;
	localparam int CHAIN_LEN = 49;
	localparam int OUT_POS = 50;
	localparam int IDX_W = 6;
	localparam logic [2:0] STRAP_CHAIN_CODE = 3'h0;
	localparam int STEP_WAIT = 4;
	localparam logic [IDX_W-1:0] LAST_IDX = 6'h30;
	localparam logic [7:0] SETTLE_CYCLES = 8'h04;
	localparam logic [IDX_W-1:0] IDX_ZERO = 6'h00;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ALLHIGH = 3'h1,
		ST_CHECKHI = 3'h3,
		ST_STEP = 3'h2,
		ST_CHECK = 3'h6,
		ST_DONE = 3'h7
	} tester_state_type;
endpackage

//--- src/nand_chain_if.sv
// Purpose: board pins between the switch device and the board test logic
// Assumes: board drives chain inputs and straps, device drives result pin
// Notes: none
`timescale 1ns/10ps
interface nand_chain_if;
	import nand_chain_pkg::*;
	logic [CHAIN_LEN-1:0] chain_in;
	logic led_group2_strap_a;
	logic led_group2_strap_b;
	logic led_group4_strap_a;
	logic chain_result_pin;
	modport device_end(input chain_in, input led_group2_strap_a,
		input led_group2_strap_b, input led_group4_strap_a, output chain_result_pin);
	modport board_end(output chain_in, output led_group2_strap_a,
		output led_group2_strap_b, output led_group4_strap_a, input chain_result_pin);
endinterface

//--- src/nand_chain_device.sv
// Purpose: device end of the pin-connectivity chain
// Assumes: straps are caught after reset release
// Notes: chain itself is combinational
//
// Operation
// - nested nand chain drives result pin
// - chain mode only on strap code
// - tester drives all high, checks high
// - fixed input order, output is position fifty
// - tester lowers inputs in order, cumulatively
// - first input low drops output
// - each further step inverts output
// - every good input toggles output
// - tester flags inputs without toggle
`timescale 1ns/10ps
module nand_chain_device (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	nand_chain_if.device_end pins,
	input wire logic normal_result_i,
	output logic chain_mode_o
);
	import nand_chain_pkg::*;
	typedef struct packed {
		logic caught;
		logic mode;
	} dev_state_type;
	dev_state_type state;
	dev_state_type next_state;
	logic [CHAIN_LEN:0] stage;
	logic [2:0] straps;
	assign straps = {pins.led_group2_strap_b, pins.led_group2_strap_a, pins.led_group4_strap_a};
	always_comb begin
		next_state = state;
		if (!state.caught) begin
			next_state.caught = 1'b1;
			next_state.mode = (straps == STRAP_CHAIN_CODE);
		end
	end
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	// position order kept by index
	// bit 0: port 6 tx clock
	// bit 1: port 6 tx enable
	// bit 2: port 6 tx error
	// bit 3: port 6 collision
	// bit 4: port 6 tx data 3
	// bit 5: port 6 tx data 2
	// bit 6: port 6 tx data 1
	// bit 7: port 6 tx data 0
	// bit 8: port 6 rx clock
	// bit 9: port 6 rx valid
	// bit 10: port 6 rx error
	// bit 11: port 6 carrier
	// bit 12: port 6 rx data 3
	// bit 13: port 6 rx data 2
	// bit 14: port 6 rx data 1
	// bit 15: port 6 rx data 0
	// bit 16: port 7 tx clock
	// bit 17: port 7 tx enable
	// bit 18: port 7 tx error
	// bit 19: port 7 collision
	// bit 20: port 7 tx data 3
	// bit 21: port 7 tx data 2
	// bit 22: port 7 tx data 1
	// bit 23: port 7 tx data 0
	// bit 24: port 7 rx clock
	// bit 25: port 7 rx valid
	// bit 26: port 7 rx error
	// bit 27: port 7 carrier
	// bit 28: port 7 rx data 3
	// bit 29: port 7 rx data 2
	// bit 30: port 7 rx data 1
	// bit 31: port 7 rx data 0
	// bit 32: led group 4 strap a
	// bit 33: led group 4 pin b
	// bit 34: led group 3 pin a
	// bit 35: led group 3 pin b
	// bit 36: general purpose pin
	// bit 37: led group 2 strap a
	// bit 38: led group 2 strap b
	// bit 39: power event pin
	// bit 40: reset pin
	// bit 41: serial data out
	// bit 42: serial data in
	// bit 43: serial select
	// bit 44: serial clock
	// bit 45: led group 5 pin a
	// bit 46: led group 5 pin b
	// bit 47: led group 1 pin a
	// bit 48: led group 1 pin b
	assign stage[0] = 1'b1;
	genvar g;
	generate
		for (g = 0; g < CHAIN_LEN; g++) begin : g_chain
			assign stage[g+1] = ~(pins.chain_in[g] & stage[g]);
		end
	endgenerate
	assign pins.chain_result_pin = state.mode ? ~stage[CHAIN_LEN] : normal_result_i;
	assign chain_mode_o = state.mode;
endmodule

//--- src/nand_chain_board.sv
// Purpose: board test logic walking the chain
// Assumes: result pin sampled synchronously
// Notes: fault_map bit i marks sequence position i+1
`timescale 1ns/10ps
module nand_chain_board (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	nand_chain_if.board_end pins,
	input wire logic start_i,
	output logic busy_o,
	output logic done_o,
	output logic high_fail_o,
	output logic [nand_chain_pkg::CHAIN_LEN-1:0] fault_map_o
);
	import nand_chain_pkg::*;
	typedef struct packed {
		tester_state_type fsm;
		logic [IDX_W-1:0] idx;
		logic [7:0] wait_cnt;
		logic expect_lvl;
		logic [CHAIN_LEN-1:0] drive;
		logic [CHAIN_LEN-1:0] faults;
		logic high_fail;
		logic done;
	} board_state_type;
	board_state_type state;
	board_state_type next_state;
	always_comb begin
		next_state = state;
		next_state.done = 1'b0;
		case (state.fsm)
			ST_IDLE: begin
				if (start_i) begin
					next_state.drive = '1;
					next_state.faults = '0;
					next_state.high_fail = 1'b0;
					next_state.wait_cnt = SETTLE_CYCLES;
					next_state.fsm = ST_ALLHIGH;
				end
			end
			ST_ALLHIGH: begin
				if (state.wait_cnt != 8'h00) begin
					next_state.wait_cnt = state.wait_cnt - 8'h01;
				end else begin
					next_state.fsm = ST_CHECKHI;
				end
			end
			ST_CHECKHI: begin
				next_state.high_fail = ~pins.chain_result_pin;
				next_state.expect_lvl = 1'b1;
				next_state.idx = IDX_ZERO;
				next_state.fsm = pins.chain_result_pin ? ST_STEP : ST_DONE;
				next_state.done = ~pins.chain_result_pin;
			end
			ST_STEP: begin
				next_state.drive[state.idx] = 1'b0;
				next_state.wait_cnt = SETTLE_CYCLES;
				next_state.fsm = ST_CHECK;
			end
			ST_CHECK: begin
				if (state.wait_cnt != 8'h00) begin
					next_state.wait_cnt = state.wait_cnt - 8'h01;
				end else begin
					next_state.faults[state.idx] = (pins.chain_result_pin == state.expect_lvl);
					next_state.expect_lvl = pins.chain_result_pin;
					if (state.idx == LAST_IDX) begin
						next_state.fsm = ST_DONE;
						next_state.done = 1'b1;
					end else begin
						next_state.idx = state.idx + 6'h01;
						next_state.fsm = ST_STEP;
					end
				end
			end
			ST_DONE: begin
				next_state.fsm = ST_IDLE;
			end
			default: begin
				next_state.fsm = ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign pins.chain_in = state.drive;
	assign pins.led_group2_strap_a = STRAP_CHAIN_CODE[1];
	assign pins.led_group2_strap_b = STRAP_CHAIN_CODE[2];
	assign pins.led_group4_strap_a = STRAP_CHAIN_CODE[0];
	assign busy_o = (state.fsm != ST_IDLE);
	assign done_o = state.done;
	assign high_fail_o = state.high_fail;
	assign fault_map_o = state.faults;
endmodule

//--- dv/nand_chain_monitor.sv
// Purpose: chain pin checks
// Assumes: board walks a thermometer pattern
// Notes: none
`timescale 1ns/10ps
module nand_chain_monitor
	import nand_chain_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [CHAIN_LEN-1:0] chain_in,
	input wire logic chain_result_pin,
	input wire logic led_group2_strap_a,
	input wire logic led_group2_strap_b,
	input wire logic led_group4_strap_a,
	input wire logic chain_mode_o,
	input wire logic normal_result_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic high_fail_o,
	input wire logic [CHAIN_LEN-1:0] fault_map_o
);
	logic [CHAIN_LEN-1:0] low;
	logic therm;
	assign low = ~chain_in;
	assign therm = (low & (low + 1'b1)) == '0;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	par_follow_a: assert property (chain_mode_o && therm |-> chain_result_pin == ^chain_in)
		else $error("result parity wrong");
	all_high_a: assert property (chain_mode_o && (&chain_in) |-> chain_result_pin)
		else $error("all high not high");
	strap_mode_a: assert property (chain_mode_o |->
		{led_group2_strap_b, led_group2_strap_a, led_group4_strap_a} == STRAP_CHAIN_CODE)
		else $error("mode without strap code");
	normal_pin_a: assert property (!chain_mode_o |-> chain_result_pin == normal_result_i)
		else $error("normal value lost");
	in_order_a: assert property (busy_o |-> therm)
		else $error("inputs out of order");
	one_step_a: assert property (busy_o && !(&chain_in) |->
		$countones($past(chain_in) ^ chain_in) <= 1)
		else $error("more than one input moved");
	settle_hold_a: assert property (busy_o && $changed(chain_in) |=> $stable(chain_in) [*5])
		else $error("step too short");
	end_clean_a: assert property (done_o && chain_mode_o |->
		chain_in == '0 && fault_map_o == '0 && !high_fail_o)
		else $error("walk ended badly");
endmodule

//--- dv/nand_chain_board_test_bench.sv
// Purpose: walks the chain end to end
// Assumes: straps select chain mode
// Notes: none
`timescale 1ns/10ps
module nand_chain_board_test_bench;
	import nand_chain_pkg::*;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic start_i = 1'b0;
	logic normal_result_i = 1'b1;
	logic busy_o, done_o, high_fail_o, chain_mode_o;
	logic [CHAIN_LEN-1:0] fault_map_o;
	int fails = 0;
	int checks = 0;
	nand_chain_if pins();
	nand_chain_device nand_chain_device_inst(.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.pins(pins), .normal_result_i(normal_result_i), .chain_mode_o(chain_mode_o));
	nand_chain_board nand_chain_board_inst(.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.pins(pins), .start_i(start_i), .busy_o(busy_o), .done_o(done_o),
		.high_fail_o(high_fail_o), .fault_map_o(fault_map_o));
	nand_chain_monitor nand_chain_monitor_inst(.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.chain_in(pins.chain_in), .chain_result_pin(pins.chain_result_pin),
		.led_group2_strap_a(pins.led_group2_strap_a), .led_group2_strap_b(pins.led_group2_strap_b),
		.led_group4_strap_a(pins.led_group4_strap_a), .chain_mode_o(chain_mode_o),
		.normal_result_i(normal_result_i), .busy_o(busy_o), .done_o(done_o),
		.high_fail_o(high_fail_o), .fault_map_o(fault_map_o));
	initial begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		checks++;
		if (seen !== want) begin
			fails++;
			$display("ERROR %0t seen %0h want %0h", $time, seen, want);
		end
	endtask
	task automatic summarize();
		if (fails == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic normal_pin();
		@(posedge clk_sys_i) normal_result_i <= 1'b0;
		@(posedge clk_sys_i) #1 check(pins.chain_result_pin, 1'b0);
		@(posedge clk_sys_i) normal_result_i <= 1'b1;
		@(posedge clk_sys_i) #1 check(pins.chain_result_pin, 1'b1);
	endtask
	task automatic walk();
		int dones;
		dones = 0;
		@(posedge clk_sys_i) start_i <= 1'b1;
		@(posedge clk_sys_i) start_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		#1 check(pins.chain_result_pin, 1'b1);
		@(posedge clk_sys_i) start_i <= 1'b1;
		@(posedge clk_sys_i) start_i <= 1'b0;
		for (int i = 0; i < 1200; i++) begin
			@(posedge clk_sys_i);
			#1 if (done_o === 1'b1) dones++;
		end
		check(dones, 1);
		check(fault_map_o, '0);
		check(high_fail_o, 1'b0);
		check(pins.chain_in, '0);
		check(pins.chain_result_pin, 1'b0);
	endtask
	initial begin
		repeat (4) @(posedge clk_sys_i);
		normal_pin();
		reset_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		#1 check(chain_mode_o, 1'b1);
		walk();
		walk();
		summarize();
	end
	initial begin
		repeat (5000) @(posedge clk_sys_i);
		fails++;
		summarize();
	end
endmodule
